// file: include/decode_consts.svh
// opcodes, register map, field positions and reset values of the instruction decoder
`ifndef DECODE_CONSTS_SVH
`define DECODE_CONSTS_SVH

// ==========================================================
// instruction codes
`define OP_NOP          10'h000
`define OP_SYS_RESET    10'h001
`define OP_CLOCK_OP     10'h002
`define OP_SKIP_P       10'h003
`define OP_RAM_BACKUP   10'h008
`define OP_UPPER_CLR    10'h058
`define OP_UPPER_SET    10'h059
`define OP_ARM_PD       10'h05b
`define OP_WR_AUX       10'h209
`define OP_WR_LCD1      10'h20a
`define OP_WR_LCD2      10'h20b
`define OP_WR_LCD3      10'h20c
`define OP_WR_MODE      10'h216
`define OP_RD_LCD1      10'h24a
`define OP_RD_MODE      10'h252
`define OP_VDROP_PD     10'h293
`define OP_SEL_RC       10'h29b
`define OP_WDT_ARM      10'h29c
`define OP_WDT_RESTART  10'h2a0
`define OP_WR_LCD4      10'h2a8
`define OP_WR_LCD5      10'h2a9

// ==========================================================
// register byte offsets
`define REG_LCD1        8'h00
`define REG_LCD2        8'h04
`define REG_LCD3        8'h08
`define REG_LCD4        8'h0c
`define REG_LCD5        8'h10
`define REG_CLOCK_MODE  8'h14
`define REG_CLOCK_AUX   8'h18
`define REG_STATUS      8'h1c
`define REG_CONTROL     8'h20

// ==========================================================
// field positions
`define ST_ARM_PD       0
`define ST_ARM_WDT      1
`define ST_WDT_STOP     2
`define ST_RC_SEL       3
`define ST_UPPER_REF    4
`define ST_VDROP_PD     5
`define CTL_VDROP_HW    0

// ==========================================================
// reset values and timing
`define RST_NIBBLE      4'h0
`define RST_WORD        32'h0000_0000
`define BUS_ANSWER_CYC  1

`endif

// file: include/decode_pkg.sv
// types shared by the instruction decoder files
package decode_pkg;

    typedef enum logic [1:0] {ARM_NONE, ARM_POWER_DOWN, ARM_WDT_STOP} arm_state_t;

    // one-hot strobes of a decoded instruction
    typedef struct packed {
        logic       read_lcd_ctl_one;
        logic [4:0] write_lcd_ctl;
        logic       select_rc_main_clock;
        logic       read_clock_mode_reg;
        logic       write_clock_mode_reg;
        logic       write_clock_aux_reg;
        logic       no_operation;
        logic       enter_clock_operating_mode;
        logic       enter_ram_backup;
        logic       arm_power_down;
        logic       skip_if_status_flag;
        logic       watchdog_restart_skip;
        logic       watchdog_stop_arm;
        logic       software_system_reset;
        logic       clear_upper_ref_enable;
        logic       set_upper_ref_enable;
        logic       enable_vdrop_in_powerdown;
        logic       known;
    } decode_t;

endpackage : decode_pkg

// file: hw/reset_sync.sv
// two-stage release synchroniser for the active-low reset
module reset_sync
(
    input  wire logic clk_in,
    input  wire logic resetn_in,
    output logic      rst_n_out
);
    logic stage_reg;

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            stage_reg <= 1'b0;
            rst_n_out <= 1'b0;
        end
        else
        begin
            stage_reg <= 1'b1;
            rst_n_out <= stage_reg;
        end
    end
endmodule : reset_sync

// file: hw/opcode_decode.sv
// combinational decode of one 10-bit program word into strobes
`include "decode_consts.svh"
module opcode_decode
    import decode_pkg::*;
(
    input  wire logic       valid_in,
    input  wire logic [9:0] instr_in,
    output decode_t         dec_out
);
    always_comb
    begin
        dec_out = '0;
        if (valid_in)
        begin
            case (instr_in)
                `OP_RD_LCD1:     dec_out.read_lcd_ctl_one           = 1'b1;
                `OP_WR_LCD1:     dec_out.write_lcd_ctl[0]           = 1'b1;
                `OP_WR_LCD2:     dec_out.write_lcd_ctl[1]           = 1'b1;
                `OP_WR_LCD3:     dec_out.write_lcd_ctl[2]           = 1'b1;
                `OP_WR_LCD4:     dec_out.write_lcd_ctl[3]           = 1'b1;
                `OP_WR_LCD5:     dec_out.write_lcd_ctl[4]           = 1'b1;
                `OP_SEL_RC:      dec_out.select_rc_main_clock       = 1'b1;
                `OP_RD_MODE:     dec_out.read_clock_mode_reg        = 1'b1;
                `OP_WR_MODE:     dec_out.write_clock_mode_reg       = 1'b1;
                `OP_WR_AUX:      dec_out.write_clock_aux_reg        = 1'b1;
                `OP_NOP:         dec_out.no_operation               = 1'b1;
                `OP_CLOCK_OP:    dec_out.enter_clock_operating_mode = 1'b1;
                `OP_RAM_BACKUP:  dec_out.enter_ram_backup           = 1'b1;
                `OP_ARM_PD:      dec_out.arm_power_down             = 1'b1;
                `OP_SKIP_P:      dec_out.skip_if_status_flag        = 1'b1;
                `OP_WDT_RESTART: dec_out.watchdog_restart_skip      = 1'b1;
                `OP_WDT_ARM:     dec_out.watchdog_stop_arm          = 1'b1;
                `OP_SYS_RESET:   dec_out.software_system_reset      = 1'b1;
                `OP_UPPER_CLR:   dec_out.clear_upper_ref_enable     = 1'b1;
                `OP_UPPER_SET:   dec_out.set_upper_ref_enable       = 1'b1;
                `OP_VDROP_PD:    dec_out.enable_vdrop_in_powerdown  = 1'b1;
                default:         dec_out.known                      = 1'b0;
            endcase
            dec_out.known = |dec_out;
        end
    end
endmodule : opcode_decode

// file: hw/lcd_clock_system_instr_decode.sv
// decoder for lcd, clock and system instructions with avalon register view
`include "decode_consts.svh"
module lcd_clock_system_instr_decode
    import decode_pkg::*;
#(
    parameter int   LCD_REGS    = 5,
    parameter int   ACC_W       = 4,
    parameter logic VDROP_HW    = 1'b1
)
(
    input  wire logic                  clk_in,
    input  wire logic                  resetn_in,
    input  wire logic                  instr_valid_in,
    input  wire logic [9:0]            instr_in,
    input  wire logic [ACC_W-1:0]      acc_in,
    input  wire logic                  status_flag_in,
    input  wire logic                  watchdog_flag_one_in,
    input  wire logic [7:0]            avs_address_in,
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [31:0]           avs_writedata_in,
    input  wire logic [3:0]            avs_byteenable_in,
    output logic [31:0]                avs_readdata_out,
    output logic                       avs_waitrequest_out,
    output logic                       acc_load_out,
    output logic [ACC_W-1:0]           acc_data_out,
    output logic                       skip_out,
    output logic                       pc_step_out,
    output logic                       sys_reset_req_out,
    output logic                       clock_op_mode_out,
    output logic                       ram_backup_out,
    output logic                       wdt_flag_clear_out,
    output logic                       wdt_stop_out,
    output logic                       rc_main_sel_out,
    output logic                       upper_bits_ref_enable_out,
    output logic                       vdrop_pd_enable_out,
    output logic [LCD_REGS*ACC_W-1:0]  lcd_ctl_out,
    output logic [ACC_W-1:0]           clock_mode_out,
    output logic [ACC_W-1:0]           clock_aux_out
);
    // ==========================================================
    // reset and decode
    logic               rst_n_sync;
    decode_t            dec;
    arm_state_t         arm_state_reg;
    arm_state_t         arm_state_next;
    logic [ACC_W-1:0]   lcd_ctl_reg [LCD_REGS];
    logic               vdrop_hw_reg;
    logic [31:0]        status_word;
    logic [31:0]        rd_mux;

    reset_sync u_reset_sync
    (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .rst_n_out (rst_n_sync)
    );

    opcode_decode u_opcode_decode
    (
        .valid_in (instr_valid_in),
        .instr_in (instr_in),
        .dec_out  (dec)
    );

    // ==========================================================
    // lcd control registers
    for (genvar i = 0; i < LCD_REGS; i++)
    begin : g_lcd
        always_ff @(posedge clk_in or negedge rst_n_sync)
        begin
            if (!rst_n_sync)
                lcd_ctl_reg[i] <= `RST_NIBBLE;
            else if (dec.write_lcd_ctl[i])
                lcd_ctl_reg[i] <= acc_in;
        end
        assign lcd_ctl_out[i*ACC_W +: ACC_W] = lcd_ctl_reg[i];
    end

    // ==========================================================
    // clock control registers
    always_ff @(posedge clk_in or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            clock_mode_out  <= `RST_NIBBLE;
            clock_aux_out   <= `RST_NIBBLE;
            rc_main_sel_out <= 1'b0;
        end
        else
        begin
            if (dec.write_clock_mode_reg)
                clock_mode_out <= acc_in;
            if (dec.write_clock_aux_reg)
                clock_aux_out <= acc_in;
            if (dec.select_rc_main_clock)
                rc_main_sel_out <= 1'b1;
        end
    end

    // ==========================================================
    // arming: holds only across the very next instruction
    always_comb
    begin
        arm_state_next = arm_state_reg;
        if (instr_valid_in)
        begin
            if (dec.arm_power_down)
                arm_state_next = ARM_POWER_DOWN;
            else if (dec.watchdog_stop_arm)
                arm_state_next = ARM_WDT_STOP;
            else
                arm_state_next = ARM_NONE;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
            arm_state_reg <= ARM_NONE;
        else
            arm_state_reg <= arm_state_next;
    end

    // ==========================================================
    // power down, watchdog and system strobes
    always_ff @(posedge clk_in or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            clock_op_mode_out  <= 1'b0;
            ram_backup_out     <= 1'b0;
            wdt_flag_clear_out <= 1'b0;
            wdt_stop_out       <= 1'b0;
            sys_reset_req_out  <= 1'b0;
            skip_out           <= 1'b0;
            pc_step_out        <= 1'b0;
        end
        else
        begin
            clock_op_mode_out  <= dec.enter_clock_operating_mode
                                  && arm_state_reg == ARM_POWER_DOWN;
            ram_backup_out     <= dec.enter_ram_backup
                                  && arm_state_reg == ARM_POWER_DOWN;
            wdt_flag_clear_out <= dec.watchdog_restart_skip && watchdog_flag_one_in;
            if (dec.watchdog_restart_skip && arm_state_reg == ARM_WDT_STOP)
                wdt_stop_out <= 1'b1;
            sys_reset_req_out  <= dec.software_system_reset;
            skip_out           <= (dec.skip_if_status_flag && status_flag_in)
                                  || (dec.watchdog_restart_skip && watchdog_flag_one_in);
            pc_step_out        <= dec.known;
        end
    end

    // ==========================================================
    // accumulator reads and flags
    always_ff @(posedge clk_in or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            acc_load_out <= 1'b0;
            acc_data_out <= `RST_NIBBLE;
        end
        else
        begin
            acc_load_out <= dec.read_lcd_ctl_one || dec.read_clock_mode_reg;
            if (dec.read_lcd_ctl_one)
                acc_data_out <= lcd_ctl_reg[0];
            else if (dec.read_clock_mode_reg)
                acc_data_out <= clock_mode_out;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            upper_bits_ref_enable_out <= 1'b0;
            vdrop_pd_enable_out       <= 1'b0;
        end
        else
        begin
            if (dec.set_upper_ref_enable)
                upper_bits_ref_enable_out <= 1'b1;
            else if (dec.clear_upper_ref_enable)
                upper_bits_ref_enable_out <= 1'b0;
            if (dec.enable_vdrop_in_powerdown && vdrop_hw_reg)
                vdrop_pd_enable_out <= 1'b1;
        end
    end

    // ==========================================================
    // avalon slave: one wait cycle, then the answer
    always_comb
    begin
        status_word = `RST_WORD;
        status_word[`ST_ARM_PD]    = arm_state_reg == ARM_POWER_DOWN;
        status_word[`ST_ARM_WDT]   = arm_state_reg == ARM_WDT_STOP;
        status_word[`ST_WDT_STOP]  = wdt_stop_out;
        status_word[`ST_RC_SEL]    = rc_main_sel_out;
        status_word[`ST_UPPER_REF] = upper_bits_ref_enable_out;
        status_word[`ST_VDROP_PD]  = vdrop_pd_enable_out;
        rd_mux = `RST_WORD;
        case (avs_address_in)
            `REG_LCD1:       rd_mux[ACC_W-1:0] = lcd_ctl_reg[0];
            `REG_LCD2:       rd_mux[ACC_W-1:0] = lcd_ctl_reg[1];
            `REG_LCD3:       rd_mux[ACC_W-1:0] = lcd_ctl_reg[2];
            `REG_LCD4:       rd_mux[ACC_W-1:0] = lcd_ctl_reg[3];
            `REG_LCD5:       rd_mux[ACC_W-1:0] = lcd_ctl_reg[4];
            `REG_CLOCK_MODE: rd_mux[ACC_W-1:0] = clock_mode_out;
            `REG_CLOCK_AUX:  rd_mux[ACC_W-1:0] = clock_aux_out;
            `REG_STATUS:     rd_mux = status_word;
            `REG_CONTROL:    rd_mux[`CTL_VDROP_HW] = vdrop_hw_reg;
            default:         rd_mux = `RST_WORD;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= `RST_WORD;
        end
        else
        begin
            avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
            if (avs_read_in && avs_waitrequest_out)
                avs_readdata_out <= rd_mux;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
            vdrop_hw_reg <= 1'b0;
        else if (!rst_n_sync)
            vdrop_hw_reg <= 1'b0;
        else if (avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
                 && avs_address_in == `REG_CONTROL)
            vdrop_hw_reg <= avs_writedata_in[`CTL_VDROP_HW];
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_sync);

    sequence s_op(logic [9:0] code);
        instr_valid_in && instr_in == code;
    endsequence
    sequence s_arm_pd;
        s_op(`OP_ARM_PD);
    endsequence

    property p_rd_lcd;
        s_op(`OP_RD_LCD1) |=> acc_load_out && acc_data_out == $past(lcd_ctl_reg[0]);
    endproperty
    a_rd_lcd: assert property (p_rd_lcd) else $error("lcd read wrong");

    for (genvar j = 0; j < LCD_REGS; j++)
    begin : g_chk
        localparam logic [9:0] WR_OP [5] = '{`OP_WR_LCD1, `OP_WR_LCD2, `OP_WR_LCD3,
                                              `OP_WR_LCD4, `OP_WR_LCD5};
        property p_wr_lcd;
            s_op(WR_OP[j]) |=> lcd_ctl_reg[j] == $past(acc_in);
        endproperty
        a_wr_lcd: assert property (p_wr_lcd) else $error("lcd write lost");
    end

    property p_rc_sel;
        s_op(`OP_SEL_RC) |=> rc_main_sel_out ##1 rc_main_sel_out;
    endproperty
    a_rc_sel: assert property (p_rc_sel) else $error("rc clock not selected");

    property p_rd_mode;
        s_op(`OP_RD_MODE) |=> acc_load_out && acc_data_out == $past(clock_mode_out);
    endproperty
    a_rd_mode: assert property (p_rd_mode) else $error("mode read wrong");

    property p_wr_mode;
        s_op(`OP_WR_MODE) |=> clock_mode_out == $past(acc_in) && $stable(clock_aux_out);
    endproperty
    a_wr_mode: assert property (p_wr_mode) else $error("mode write wrong");

    property p_wr_aux;
        s_op(`OP_WR_AUX) |=> clock_aux_out == $past(acc_in) && !acc_load_out;
    endproperty
    a_wr_aux: assert property (p_wr_aux) else $error("aux write wrong");

    property p_clock_op;
        s_arm_pd ##1 s_op(`OP_CLOCK_OP) |=> clock_op_mode_out ##1 !clock_op_mode_out;
    endproperty
    a_clock_op: assert property (p_clock_op) else $error("clock mode not entered");

    property p_ram_bk;
        s_arm_pd ##1 s_op(`OP_RAM_BACKUP) |=> ram_backup_out && !clock_op_mode_out;
    endproperty
    a_ram_bk: assert property (p_ram_bk) else $error("backup mode not entered");

    property p_unarmed;
        arm_state_reg != ARM_POWER_DOWN && instr_valid_in
            && (instr_in == `OP_CLOCK_OP || instr_in == `OP_RAM_BACKUP)
            |=> !clock_op_mode_out && !ram_backup_out;
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("power down without arming");

    property p_wdt_stop;
        s_op(`OP_WDT_ARM) ##1 s_op(`OP_WDT_RESTART) |=> wdt_stop_out;
    endproperty
    a_wdt_stop: assert property (p_wdt_stop) else $error("watchdog not stopped");

    property p_vdrop;
        s_op(`OP_VDROP_PD) ##0 vdrop_hw_reg |=> vdrop_pd_enable_out;
    endproperty
    a_vdrop: assert property (p_vdrop) else $error("vdrop not enabled");

    property p_nop;
        s_op(`OP_NOP) |=> pc_step_out && !skip_out && !acc_load_out && !sys_reset_req_out
            && $stable(lcd_ctl_out) && $stable(clock_mode_out) && $stable(clock_aux_out);
    endproperty
    a_nop: assert property (p_nop) else $error("nop had side effect");

    property p_skip_p;
        s_op(`OP_SKIP_P) |=> skip_out == $past(status_flag_in) && !wdt_flag_clear_out;
    endproperty
    a_skip_p: assert property (p_skip_p) else $error("status skip wrong");

    property p_wdt_rst;
        s_op(`OP_WDT_RESTART) |=> skip_out == $past(watchdog_flag_one_in)
            && wdt_flag_clear_out == $past(watchdog_flag_one_in);
    endproperty
    a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog restart wrong");

    property p_upper;
        (s_op(`OP_UPPER_SET) |=> upper_bits_ref_enable_out)
        and (s_op(`OP_UPPER_CLR) |=> !upper_bits_ref_enable_out);
    endproperty
    a_upper: assert property (p_upper) else $error("upper ref flag wrong");

    property p_sys_rst;
        s_op(`OP_SYS_RESET) |=> sys_reset_req_out ##1 !sys_reset_req_out;
    endproperty
    a_sys_rst: assert property (p_sys_rst) else $error("reset request wrong");

    property p_one_cycle;
        instr_valid_in && dec.known |=> pc_step_out;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("instruction not done");

endmodule : lcd_clock_system_instr_decode

// file: test/fetch_model.sv
// instruction fetch model that presents one program word at a time
module fetch_model
(
    input  wire logic       clk_in,
    output logic            instr_valid_out,
    output logic [9:0]      instr_out,
    output logic [3:0]      acc_out,
    output logic            status_flag_out,
    output logic            watchdog_flag_one_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        instr_valid_out = 1'b0;
        instr_out = 10'h3ff;
        acc_out = 4'h0;
        status_flag_out = 1'b0;
        watchdog_flag_one_out = 1'b0;
    end
    // one word, one cycle, then the lines show the inverse
    task put(input logic [9:0] w, input logic [3:0] a = 4'h0,
             input logic p = 1'b0, input logic f = 1'b0);
        @(posedge clk_in);
        instr_valid_out <= 1'b1;
        instr_out <= w;
        acc_out <= a;
        status_flag_out <= p;
        watchdog_flag_one_out <= f;
        @(posedge clk_in);
        instr_valid_out <= 1'b0;
        instr_out <= ~w;
        acc_out <= ~a;
        status_flag_out <= ~p;
        watchdog_flag_one_out <= ~f;
        #1;
    endtask : put
endmodule : fetch_model

// file: test/lcd_clock_system_instr_decode_tb_top.sv
// self-checking bench of the lcd, clock and system instruction decoder
`include "decode_consts.svh"
module lcd_clock_system_instr_decode_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, resetn_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
    logic [7:0] avs_address_in = 8'h00;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
    logic instr_valid_in, status_flag_in, watchdog_flag_one_in;
    logic [9:0] instr_in;
    logic [3:0] acc_in, acc_data_out, clock_mode_out, clock_aux_out;
    logic [19:0] lcd_ctl_out;
    logic avs_waitrequest_out, acc_load_out, skip_out, pc_step_out, sys_reset_req_out;
    logic clock_op_mode_out, ram_backup_out, wdt_flag_clear_out, wdt_stop_out;
    logic rc_main_sel_out, upper_bits_ref_enable_out, vdrop_pd_enable_out;
    int err_total = 0, samples_checked = 0;
    always #4 clk_in = ~clk_in;
    fetch_model u_fetch (.clk_in, .instr_valid_out(instr_valid_in), .instr_out(instr_in),
        .acc_out(acc_in), .status_flag_out(status_flag_in),
        .watchdog_flag_one_out(watchdog_flag_one_in));
    lcd_clock_system_instr_decode u_dut (.clk_in, .resetn_in, .instr_valid_in, .instr_in,
        .acc_in, .status_flag_in, .watchdog_flag_one_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hf), .avs_readdata_out,
        .avs_waitrequest_out, .acc_load_out, .acc_data_out, .skip_out, .pc_step_out,
        .sys_reset_req_out, .clock_op_mode_out, .ram_backup_out, .wdt_flag_clear_out,
        .wdt_stop_out, .rc_main_sel_out, .upper_bits_ref_enable_out, .vdrop_pd_enable_out,
        .lcd_ctl_out, .clock_mode_out, .clock_aux_out);
    // ==========================================================
    // shared tasks
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        avs_read_in <= !w;
        avs_write_in <= w;
        avs_address_in <= a;
        avs_writedata_in <= d;
        do
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        while (avs_waitrequest_out !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            err_total++;
            $display("BAD bus wait expected 0 seen %b", avs_waitrequest_out);
            end_of_test();
        end
        @(posedge clk_in);
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask : bus
    // ==========================================================
    // scenarios
    task t_lcd;
        logic [9:0] ops [5];
        ops = '{`OP_WR_LCD1, `OP_WR_LCD2, `OP_WR_LCD3, `OP_WR_LCD4, `OP_WR_LCD5};
        for (int i = 0; i < 5; i++)
        begin
            u_fetch.put(ops[i], 4'(i + 9));
            chk("lcd", 32'(i + 9), 32'(lcd_ctl_out[4*i +: 4]));
            chk("pc step", 32'h1, 32'(pc_step_out));
        end
        u_fetch.put(`OP_RD_LCD1);
        chk("acc load", 32'h1, 32'(acc_load_out));
        chk("acc data", 32'h9, 32'(acc_data_out));
        bus(1'b0, `REG_LCD5, 32'h0);
        chk("lcd5 reg", 32'hd, q);
        bus(1'b1, `REG_LCD1, 32'h3);
        bus(1'b0, `REG_LCD1, 32'h0);
        chk("lcd1 ro", 32'h9, q);
        $display("lcd test done");
    endtask : t_lcd
    task t_clock;
        u_fetch.put(`OP_WR_MODE, 4'ha);
        chk("mode", 32'ha, 32'(clock_mode_out));
        u_fetch.put(`OP_RD_MODE);
        chk("acc mode", 32'ha, 32'(acc_data_out));
        u_fetch.put(`OP_WR_AUX, 4'h6);
        chk("aux", 32'h6, 32'(clock_aux_out));
        chk("rc before", 32'h0, 32'(rc_main_sel_out));
        u_fetch.put(`OP_SEL_RC);
        chk("rc", 32'h1, 32'(rc_main_sel_out));
        $display("clock test done");
    endtask : t_clock
    task t_power;
        u_fetch.put(`OP_CLOCK_OP);
        chk("unarmed", 32'h0, 32'(clock_op_mode_out));
        u_fetch.put(`OP_ARM_PD);
        u_fetch.put(`OP_CLOCK_OP);
        chk("clock op", 32'h1, 32'(clock_op_mode_out));
        u_fetch.put(`OP_ARM_PD);
        u_fetch.put(`OP_NOP);
        chk("nop step", 32'h1, 32'(pc_step_out));
        u_fetch.put(`OP_RAM_BACKUP);
        chk("stale arm", 32'h0, 32'(ram_backup_out));
        u_fetch.put(`OP_ARM_PD);
        u_fetch.put(`OP_RAM_BACKUP);
        chk("backup", 32'h1, 32'(ram_backup_out));
        $display("power test done");
    endtask : t_power
    task t_watch;
        u_fetch.put(`OP_WDT_RESTART, 4'h0, 1'b0, 1'b1);
        chk("wdt skip", 32'h3, 32'({skip_out, wdt_flag_clear_out}));
        u_fetch.put(`OP_WDT_RESTART);
        chk("wdt none", 32'h0, 32'({skip_out, wdt_flag_clear_out, wdt_stop_out}));
        u_fetch.put(`OP_WDT_ARM);
        u_fetch.put(`OP_WDT_RESTART);
        chk("wdt stop", 32'h1, 32'(wdt_stop_out));
        u_fetch.put(`OP_SKIP_P, 4'h0, 1'b1);
        chk("p skip", 32'h1, 32'(skip_out));
        u_fetch.put(`OP_SKIP_P);
        chk("p none", 32'h0, 32'(skip_out));
        $display("watchdog test done");
    endtask : t_watch
    task t_misc;
        u_fetch.put(`OP_UPPER_SET);
        chk("upper set", 32'h1, 32'(upper_bits_ref_enable_out));
        u_fetch.put(`OP_UPPER_CLR);
        chk("upper clr", 32'h0, 32'(upper_bits_ref_enable_out));
        u_fetch.put(`OP_SYS_RESET);
        chk("sys reset", 32'h1, 32'(sys_reset_req_out));
        bus(1'b1, `REG_CONTROL, 32'h1);
        u_fetch.put(`OP_VDROP_PD);
        chk("vdrop", 32'h1, 32'(vdrop_pd_enable_out));
        bus(1'b0, `REG_STATUS, 32'h0);
        chk("status", 32'h2c, q);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("misc test done");
    endtask : t_misc
    initial
    begin
        repeat (4) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        t_lcd();
        t_clock();
        t_power();
        t_watch();
        t_misc();
        end_of_test();
    end
endmodule : lcd_clock_system_instr_decode_tb_top
